// [config_mode_loader.sv]
// configuration mode loader: mode pins, clocks, addresses, bit parser
//
// Chosen here: the Wishbone register port and the placing of the registers.
`timescale 1ns/1ps

module config_mode_loader (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic mode_sel_2_i,
  input wire logic mode_sel_1_i,
  input wire logic mode_sel_0_i,
  output logic mode_sel_1_o,
  output logic mode_sel_1_oe_o,
  output logic aux_input_pad_2_o,
  output logic aux_input_pad_0_o,
  input wire logic aux_output_pad_1_i,
  input wire logic config_clock_i,
  output logic config_clock_o,
  output logic config_clock_oe_o,
  input wire logic din_i,
  output logic dout_o,
  input wire logic [7:0] data_i,
  input wire logic wr_n_i,
  output logic rdy_busy_o,
  output logic [17:0] prom_addr_o,
  output logic prom_addr_oe_o,
  output logic [3:0] upper_prom_address_o,
  output logic upper_prom_address_oe_o,
  output logic init_n_o,
  output logic init_n_oe_o,
  output logic done_o
);

  function automatic logic is_master_f(input cml_pkg::mode_type m);
    is_master_f = (m == cml_pkg::MODE_MSER) || (m == cml_pkg::MODE_MPUP) ||
                  (m == cml_pkg::MODE_MPDN);
  endfunction

  function automatic logic is_par_f(input cml_pkg::mode_type m);
    is_par_f = (m == cml_pkg::MODE_MPUP) || (m == cml_pkg::MODE_MPDN);
  endfunction

  function automatic logic is_per_f(input cml_pkg::mode_type m);
    is_per_f = (m == cml_pkg::MODE_SPER) || (m == cml_pkg::MODE_APER);
  endfunction

  function automatic logic [21:0] start_addr_f(input cml_pkg::mode_type m,
                                               input logic w);
    if (m != cml_pkg::MODE_MPDN)
      start_addr_f = 22'h0;
    else if (w)
      start_addr_f = cml_pkg::DOWN_START_22;
    else
      start_addr_f = cml_pkg::DOWN_START_18;
  endfunction

  logic [13:0] meta_ff;
  logic [13:0] pin_ff;
  logic config_clock_prev_ff;
  logic wr_prev_ff;
  logic [1:0] start_cnt_ff;
  logic latched_ff;
  cml_pkg::mode_type mode_ff;
  logic [7:0] half_cnt_ff;
  logic icclk_ff;
  logic fast_use_ff;
  logic have_ff;
  logic [7:0] byte_ff;
  logic [2:0] bitn_ff;
  logic [21:0] addr_ff;
  logic began_ff;
  cml_pkg::parse_type pstate_ff;
  logic [3:0] sh_ff;
  logic [11:0] pcnt_ff;
  logic [23:0] len_ff;
  logic [11:0] frames_ff;
  logic [23:0] clkcnt_ff;
  logic addr22_ff;
  logic done_ff;
  logic last_bit_ff;
  logic dout_ff;
  logic pad1_ff;
  logic [2:0] ctrl_ff;
  logic [11:0] fbits_ff;
  logic [11:0] fcount_ff;
  logic ack_ff;
  logic [31:0] rdat_ff;

  logic [2:0] mode_pins;
  logic config_clock_s;
  logic din_s;
  logic wr_n_s;
  logic [7:0] byte_s;
  logic reserved;
  logic master;
  logic par;
  logic per;
  logic ext_clk;
  logic active;
  logic run;
  logic [7:0] half;
  logic tick;
  logic rise;
  logic fall;
  logic load_par;
  logic load_host;
  logic cbit_v;
  logic cbit;
  logic [3:0] sh_nxt;
  logic len_ok;
  logic wide;
  logic [21:0] start_addr;
  logic hit;
  logic err;

  // pins from outside the clock domain: two flops before any use
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      meta_ff <= cml_pkg::PIN_RST;
      pin_ff <= cml_pkg::PIN_RST;
    end
    else
    begin
      meta_ff <= {mode_sel_2_i, mode_sel_1_i, mode_sel_0_i, config_clock_i,
                  din_i, wr_n_i, data_i};
      pin_ff <= meta_ff;
    end
  end

  assign mode_pins = pin_ff[13:11];
  assign config_clock_s = pin_ff[10];
  assign din_s = pin_ff[9];
  assign wr_n_s = pin_ff[8];
  assign byte_s = pin_ff[7:0];

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      config_clock_prev_ff <= 1'b0;
      wr_prev_ff <= 1'b1;
    end
    else
    begin
      config_clock_prev_ff <= config_clock_s;
      wr_prev_ff <= wr_n_s;
    end
  end

  // wait for the synchroniser to fill before trusting the mode pins
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      start_cnt_ff <= 2'h0;
      latched_ff <= 1'b0;
      mode_ff <= cml_pkg::MODE_SSER;
    end
    else if (!latched_ff)
    begin
      start_cnt_ff <= start_cnt_ff + 2'h1;
      if (start_cnt_ff == 2'h3)
      begin
        latched_ff <= 1'b1;
        mode_ff <= cml_pkg::mode_type'(mode_pins);
      end
    end
  end

  assign reserved = (mode_ff == cml_pkg::MODE_RSV1) ||
                    (mode_ff == cml_pkg::MODE_RSV2);
  assign master = is_master_f(mode_ff);
  assign par = is_par_f(mode_ff);
  assign per = is_per_f(mode_ff);
  assign ext_clk = (mode_ff == cml_pkg::MODE_SSER) ||
                   (mode_ff == cml_pkg::MODE_SPER);
  assign err = (pstate_ff == cml_pkg::P_ERR);
  assign active = latched_ff && !reserved && !done_ff;

  // internal clock: free running in master modes, a burst per byte in
  // asynchronous peripheral mode; kept running after a check error
  assign run = active && (master || ((mode_ff == cml_pkg::MODE_APER) &&
               (have_ff || icclk_ff)));
  assign half = fast_use_ff ? cml_pkg::FAST_HALF : cml_pkg::SLOW_HALF;
  // compare with >= so a switch to fast mid-phase cannot overrun the count
  assign tick = run && (half_cnt_ff >= half - 8'h01);

  always_ff @(posedge clk_i)
  begin
    if (rst_i || !run)
    begin
      half_cnt_ff <= 8'h00;
      icclk_ff <= 1'b0;
    end
    else if (tick)
    begin
      half_cnt_ff <= 8'h00;
      icclk_ff <= !icclk_ff;
    end
    else
    begin
      half_cnt_ff <= half_cnt_ff + 8'h01;
    end
  end

  // external edges are found by sampling; the link clock must be slow enough
  assign rise = ext_clk ? (config_clock_s && !config_clock_prev_ff) : (tick && !icclk_ff);
  assign fall = ext_clk ? (!config_clock_s && config_clock_prev_ff) : (tick && icclk_ff);

  assign load_par = active && par && fall && !have_ff;
  assign load_host = active && per && !wr_n_s && wr_prev_ff &&
                     !have_ff;
  assign cbit_v = active && !err && rise &&
                  ((par || per) ? have_ff : 1'b1);
  assign cbit = (par || per) ? byte_ff[0] : din_s;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      have_ff <= 1'b0;
      byte_ff <= 8'h00;
      bitn_ff <= 3'h0;
    end
    else if (load_par || load_host)
    begin
      have_ff <= 1'b1;
      byte_ff <= byte_s;
      bitn_ff <= 3'h0;
    end
    else if (active && rise && have_ff)
    begin
      byte_ff <= {1'b0, byte_ff[7:1]};
      bitn_ff <= bitn_ff + 3'h1;
      if (bitn_ff == 3'h7)
      begin
        have_ff <= 1'b0;
      end
    end
  end

  // prom address: shows the start value until the first byte is fetched
  assign wide = ctrl_ff[cml_pkg::CTRL_LOWV] || ctrl_ff[cml_pkg::CTRL_EXTA];
  assign start_addr = start_addr_f(mode_ff, wide);

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      addr_ff <= 22'h0;
      began_ff <= 1'b0;
    end
    else if (load_par)
    begin
      began_ff <= 1'b1;
      if (mode_ff == cml_pkg::MODE_MPDN)
        addr_ff <= addr_ff - 22'h1;
      else
        addr_ff <= addr_ff + 22'h1;
    end
    else if (!latched_ff)
    begin
      // preload from the pins so the start value is ready when oe rises
      addr_ff <= start_addr_f(cml_pkg::mode_type'(mode_pins), wide);
    end
    else if (!began_ff)
    begin
      addr_ff <= start_addr;
    end
  end

  assign sh_nxt = {sh_ff[2:0], cbit};

  // bit parser: preamble, length, fill, then frames with a check nibble
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pstate_ff <= cml_pkg::P_HUNT;
      sh_ff <= 4'h0;
      pcnt_ff <= 12'h0;
      len_ff <= 24'h0;
      frames_ff <= 12'h0;
      addr22_ff <= 1'b0;
      fast_use_ff <= 1'b0;
    end
    else if (cbit_v)
    begin
      sh_ff <= sh_nxt;
      pcnt_ff <= pcnt_ff + 12'h1;
      case (pstate_ff)
        cml_pkg::P_HUNT:
        begin
          if (sh_nxt == cml_pkg::PREAMBLE)
          begin
            pstate_ff <= cml_pkg::P_LEN;
            pcnt_ff <= 12'h0;
          end
        end
        cml_pkg::P_LEN:
        begin
          len_ff <= {len_ff[22:0], cbit};
          if (pcnt_ff == cml_pkg::LEN_LAST)
          begin
            pstate_ff <= cml_pkg::P_FILL;
            pcnt_ff <= 12'h0;
          end
        end
        cml_pkg::P_FILL:
        begin
          if (pcnt_ff == 12'h0)
            addr22_ff <= !cbit;
          if (pcnt_ff == cml_pkg::NIB_LAST)
            pstate_ff <= cml_pkg::P_START;
        end
        cml_pkg::P_START:
        begin
          pcnt_ff <= 12'h0;
          if (!cbit)
          begin
            pstate_ff <= cml_pkg::P_DATA;
            if (frames_ff == 12'h0)
              fast_use_ff <= ctrl_ff[cml_pkg::CTRL_FAST];
          end
        end
        cml_pkg::P_DATA:
        begin
          if (pcnt_ff == fbits_ff - 12'h1)
          begin
            pstate_ff <= cml_pkg::P_CHECK;
            pcnt_ff <= 12'h0;
          end
        end
        cml_pkg::P_CHECK:
        begin
          if (pcnt_ff == cml_pkg::NIB_LAST)
          begin
            if (sh_nxt != cml_pkg::CHECK_CODE)
              pstate_ff <= cml_pkg::P_ERR;
            else if (frames_ff + 12'h1 == fcount_ff)
              pstate_ff <= cml_pkg::P_LOADED;
            else
              pstate_ff <= cml_pkg::P_START;
            frames_ff <= frames_ff + 12'h1;
          end
        end
        cml_pkg::P_LOADED:
        begin
          pcnt_ff <= 12'h0;
        end
        default:
        begin
          pstate_ff <= cml_pkg::P_ERR;
        end
      endcase
    end
  end

  // every clock that passes a bit to the parser is counted from the start of loading
  assign len_ok = (pstate_ff != cml_pkg::P_HUNT) &&
                  (pstate_ff != cml_pkg::P_LEN);

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      clkcnt_ff <= 24'h0;
      done_ff <= 1'b0;
      last_bit_ff <= 1'b1;
    end
    else if (cbit_v)
    begin
      clkcnt_ff <= clkcnt_ff + 24'h1;
      // own bits are never forwarded, only those after loading
      last_bit_ff <= (pstate_ff == cml_pkg::P_LOADED) ? cbit : 1'b1;
      if (len_ok && (clkcnt_ff + 24'h1 == len_ff))
        done_ff <= 1'b1;
    end
  end

  // daisy chain output: high until loaded, then retimed surplus data
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      dout_ff <= 1'b1;
    else if (latched_ff && !reserved && fall)
      dout_ff <= (pstate_ff == cml_pkg::P_LOADED) ?
                 last_bit_ff : 1'b1;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      pad1_ff <= 1'b0;
    else
      pad1_ff <= aux_output_pad_1_i;
  end

  // register slave: one wait state, writes land when the request is seen
  assign hit = wb_cyc_i && wb_stb_i && !ack_ff;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ctrl_ff <= cml_pkg::CTRL_RST;
      fbits_ff <= cml_pkg::FBITS_RST;
      fcount_ff <= cml_pkg::FCOUNT_RST;
    end
    else if (hit && wb_we_i)
    begin
      if (wb_adr_i == cml_pkg::ADR_CTRL && wb_sel_i[0])
        ctrl_ff <= wb_dat_i[2:0];
      if (wb_adr_i == cml_pkg::ADR_FRAME)
      begin
        if (wb_sel_i[0])
          fbits_ff[7:0] <= wb_dat_i[7:0];
        if (wb_sel_i[1])
          fbits_ff[11:8] <= wb_dat_i[11:8];
        if (wb_sel_i[2])
          fcount_ff[7:0] <= wb_dat_i[23:16];
        if (wb_sel_i[3])
          fcount_ff[11:8] <= wb_dat_i[27:24];
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_ff <= 1'b0;
      rdat_ff <= 32'h0;
    end
    else
    begin
      ack_ff <= hit;
      if (hit)
      begin
        case (wb_adr_i)
          cml_pkg::ADR_CTRL: rdat_ff <= {29'h0, ctrl_ff};
          cml_pkg::ADR_FRAME:
            rdat_ff <= {4'h0, fcount_ff, 4'h0, fbits_ff};
          cml_pkg::ADR_STATUS:
            rdat_ff <= {23'h0, have_ff, addr22_ff, err, done_ff,
                        (pstate_ff == cml_pkg::P_LOADED), latched_ff,
                        mode_ff};
          cml_pkg::ADR_LENGTH: rdat_ff <= {8'h0, len_ff};
          default: rdat_ff <= 32'h0;
        endcase
      end
    end
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = rdat_ff;

  assign config_clock_o = icclk_ff;
  assign config_clock_oe_o = active && (master ||
                             (mode_ff == cml_pkg::MODE_APER));
  assign prom_addr_o = addr_ff[17:0];
  assign prom_addr_oe_o = active && par;
  assign upper_prom_address_o = addr_ff[21:18];
  assign upper_prom_address_oe_o = active && par &&
                                   (ctrl_ff[cml_pkg::CTRL_LOWV] ||
                                    (ctrl_ff[cml_pkg::CTRL_EXTA] &&
                                     addr22_ff));
  assign rdy_busy_o = active && per && !have_ff;
  assign dout_o = dout_ff;
  assign init_n_o = 1'b0;
  assign init_n_oe_o = err;
  assign done_o = done_ff;
  assign mode_sel_1_o = pad1_ff;
  assign mode_sel_1_oe_o = done_ff;
  assign aux_input_pad_2_o = done_ff && pin_ff[13];
  assign aux_input_pad_0_o = done_ff && pin_ff[11];
endmodule

// [cml_pkg.sv]
// constants, modes and parser states for the configuration mode loader
package cml_pkg;
  localparam int CLK_HZ = 250_000_000;
  localparam int SLOW_HZ = 1_000_000;
  localparam int FAST_HZ = 8_000_000;
  // half periods round down so the clock never runs below the nominal rate
  localparam int SLOW_HALF_INT = CLK_HZ / (2 * SLOW_HZ);
  localparam int FAST_HALF_INT = CLK_HZ / (2 * FAST_HZ);
  localparam logic [7:0] SLOW_HALF = SLOW_HALF_INT[7:0];
  localparam logic [7:0] FAST_HALF = FAST_HALF_INT[7:0];

  typedef enum logic [2:0] {
    MODE_MSER = 3'b000,
    MODE_RSV1 = 3'b001,
    MODE_RSV2 = 3'b010,
    MODE_SPER = 3'b011,
    MODE_MPUP = 3'b100,
    MODE_APER = 3'b101,
    MODE_MPDN = 3'b110,
    MODE_SSER = 3'b111
  } mode_type;

  typedef enum logic [2:0] {
    P_HUNT = 3'b000,
    P_LEN = 3'b001,
    P_FILL = 3'b010,
    P_START = 3'b011,
    P_DATA = 3'b100,
    P_CHECK = 3'b101,
    P_LOADED = 3'b110,
    P_ERR = 3'b111
  } parse_type;

  localparam logic [3:0] PREAMBLE = 4'h2;
  localparam logic [3:0] CHECK_CODE = 4'h6;
  localparam logic [11:0] LEN_LAST = 12'h017;
  localparam logic [11:0] NIB_LAST = 12'h003;
  localparam logic [21:0] DOWN_START_18 = 22'h3_ffff;
  localparam logic [21:0] DOWN_START_22 = 22'h3f_ffff;
  localparam logic [13:0] PIN_RST = 14'h3b00;

  localparam logic [7:0] ADR_CTRL = 8'h00;
  localparam logic [7:0] ADR_FRAME = 8'h04;
  localparam logic [7:0] ADR_STATUS = 8'h08;
  localparam logic [7:0] ADR_LENGTH = 8'h0c;
  localparam int CTRL_FAST = 0;
  localparam int CTRL_LOWV = 1;
  localparam int CTRL_EXTA = 2;
  localparam logic [2:0] CTRL_RST = 3'h0;
  localparam logic [11:0] FBITS_RST = 12'h07e;
  localparam logic [11:0] FCOUNT_RST = 12'h001;
endpackage

// [cml_props.sv]
// port assertions for the configuration mode loader
`timescale 1ns/1ps
module cml_props (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_ack_o,
  input wire logic config_clock_o,
  input wire logic config_clock_oe_o,
  input wire logic [17:0] prom_addr_o,
  input wire logic prom_addr_oe_o,
  input wire logic upper_prom_address_oe_o,
  input wire logic init_n_oe_o,
  input wire logic rdy_busy_o,
  input wire logic dout_o,
  input wire logic done_o,
  input wire logic mode_sel_1_oe_o,
  input wire logic aux_input_pad_2_o,
  input wire logic aux_input_pad_0_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  property p_rst_quiet;
    $fell(rst_i) |-> !config_clock_oe_o && !prom_addr_oe_o && !init_n_oe_o
      && dout_o && !done_o && !wb_ack_o;
  endproperty
  a_rst_quiet: assert property (p_rst_quiet)
    else $error("outputs active after reset");
  property p_ack_pulse;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse)
    else $error("ack longer than one cycle");
  property p_user_pins;
    !done_o |-> !mode_sel_1_oe_o && !aux_input_pad_2_o && !aux_input_pad_0_o;
  endproperty
  a_user_pins: assert property (p_user_pins)
    else $error("mode pins in user role before done");
  property p_init_holds;
    init_n_oe_o |=> init_n_oe_o;
  endproperty
  a_init_holds: assert property (p_init_holds)
    else $error("init released without reset");
  property p_busy_min;
    $fell(rdy_busy_o) |=> !rdy_busy_o [*8];
  endproperty
  a_busy_min: assert property (p_busy_min)
    else $error("ready too soon after a byte");
  property p_config_clock_half;
    config_clock_oe_o && $changed(config_clock_o) |=>
      $stable(config_clock_o) [*8];
  endproperty
  a_config_clock_half: assert property (p_config_clock_half)
    else $error("config clock phase too short");
  property p_upper_lower;
    upper_prom_address_oe_o |-> prom_addr_oe_o;
  endproperty
  a_upper_lower: assert property (p_upper_lower)
    else $error("upper address driven alone");
  property p_addr_step;
    prom_addr_oe_o && $stable(prom_addr_oe_o) && $changed(prom_addr_o)
      |-> $fell(config_clock_o);
  endproperty
  a_addr_step: assert property (p_addr_step)
    else $error("address stepped off the clock fall");
endmodule

bind config_mode_loader cml_props cml_props_inst (
  .clk_i, .rst_i, .wb_ack_o, .config_clock_o, .config_clock_oe_o,
  .prom_addr_o, .prom_addr_oe_o, .upper_prom_address_oe_o, .init_n_oe_o,
  .rdy_busy_o, .dout_o, .done_o, .mode_sel_1_oe_o, .aux_input_pad_2_o,
  .aux_input_pad_0_o
);

// [serial_source.sv]
// serial source model: link clock and data for slave serial loading
`timescale 1ns/1ps
module serial_source (
  output logic link_clk_o,
  output logic link_dat_o
);
  initial
  begin
    link_clk_o = 1'b0;
    link_dat_o = 1'b0;
  end
  // clock idles low between bits; data flips after hold so none is stale
  task automatic send_bit(input logic b);
    link_dat_o = b;
    #62.5 link_clk_o = 1'b1;
    #24 link_dat_o = ~b;
    #38.5 link_clk_o = 1'b0;
  endtask
  task automatic send_stream(input logic q[$]);
    foreach (q[i])
      send_bit(q[i]);
  endtask
endmodule

// [tb_top.sv]
// self-checking bench for the configuration mode loader
`timescale 1ns/1ps
module tb_top;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0000_0000;
  logic [2:0] pins = 3'h7;
  logic [7:0] data_i = 8'h00;
  logic wr_n_i = 1'b1;
  logic aux_i = 1'b0;
  logic [31:0] wb_dat_o, rd;
  logic [17:0] prom_addr_o;
  logic [3:0] upper_prom_address_o;
  logic [23:0] len;
  logic wb_ack_o, m1_wire, config_clock_wire, link_clk, link_dat, dout_o, done_o;
  logic mode_sel_1_o, mode_sel_1_oe_o, aux_input_pad_2_o, aux_input_pad_0_o;
  logic config_clock_o, config_clock_oe_o, rdy_busy_o, init_n_o, init_n_oe_o;
  logic prom_addr_oe_o, upper_prom_address_oe_o;
  logic strm[$];
  int fails = 0;
  int samples_checked = 0;
  always #2 clk_i = ~clk_i;
  // a shared pin follows its driver while enabled, else the outside level
  assign m1_wire = mode_sel_1_oe_o ? mode_sel_1_o : pins[1];
  assign config_clock_wire = config_clock_oe_o ? config_clock_o : link_clk;
  serial_source serial_source_inst (
    .link_clk_o(link_clk),
    .link_dat_o(link_dat)
  );
  config_mode_loader config_mode_loader_inst (
    .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i(4'hf), .wb_dat_i, .wb_dat_o, .wb_ack_o,
    .mode_sel_2_i(pins[2]), .mode_sel_1_i(m1_wire), .mode_sel_0_i(pins[0]),
    .mode_sel_1_o, .mode_sel_1_oe_o, .aux_input_pad_2_o, .aux_input_pad_0_o,
    .aux_output_pad_1_i(aux_i), .config_clock_i(config_clock_wire), .config_clock_o,
    .config_clock_oe_o, .din_i(link_dat), .dout_o, .data_i, .wr_n_i,
    .rdy_busy_o, .prom_addr_o, .prom_addr_oe_o, .upper_prom_address_o,
    .upper_prom_address_oe_o, .init_n_o, .init_n_oe_o, .done_o
  );
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      fails++;
      $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("fails %0d samples_checked %0d", fails, samples_checked);
    if (fails == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic give_up;
    fails++;
    tally_and_finish();
  endtask
  task automatic reset_dut(input logic [2:0] code);
    @(posedge clk_i);
    rst_i <= 1'b1;
    pins <= code;
    aux_i <= 1'($urandom);
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (30) @(posedge clk_i);
  endtask
  task automatic wb_xfer(input logic we, input logic [7:0] adr,
                         input logic [31:0] wd);
    int n;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= wd;
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (wb_ack_o !== 1'b1 && n < 20);
    if (wb_ack_o !== 1'b1)
      give_up();
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask
  task automatic run_serial(input logic [3:0] chk);
    logic [7:0] d;
    logic [52:0] s;
    reset_dut(3'h7);
    wb_xfer(1'b1, cml_pkg::ADR_FRAME, 32'h0001_0008);
    len = {1'b1, 23'($urandom)};
    d = 8'($urandom);
    s = {8'hff, cml_pkg::PREAMBLE, len, 4'hf, 1'b0, d, chk};
    strm = {};
    for (int i = 52; i >= 0; i--)
      strm.push_back(s[i]);
    serial_source_inst.send_stream(strm);
    repeat (10) @(posedge clk_i);
    wb_xfer(1'b0, cml_pkg::ADR_LENGTH, 32'h0000_0000);
    check(rd, {8'h00, len});
    wb_xfer(1'b0, cml_pkg::ADR_STATUS, 32'h0000_0000);
    check(rd[8:0], chk == cml_pkg::CHECK_CODE ? 9'h01f : 9'h04f);
    check(init_n_oe_o, chk != cml_pkg::CHECK_CODE);
    check(done_o, 1'b0);
    check(dout_o, 1'b1);
    // extra bits after loading go straight on to the next device
    for (int i = 0; chk == cml_pkg::CHECK_CODE && i < 6; i++)
    begin
      d[0] = 1'($urandom);
      serial_source_inst.send_bit(d[0]);
      repeat (5) @(posedge clk_i);
      check(dout_o, d[0]);
    end
  endtask
  task automatic run_async;
    int n;
    int rises;
    logic prev;
    reset_dut(3'h5);
    @(posedge clk_i);
    data_i <= 8'($urandom);
    wr_n_i <= 1'b0;
    n = 0;
    while (rdy_busy_o !== 1'b0 && n < 20)
    begin
      @(posedge clk_i);
      n++;
    end
    check(rdy_busy_o, 1'b0);
    rises = 0;
    prev = config_clock_o;
    n = 0;
    // a second write lands while busy and must be dropped
    while (rdy_busy_o !== 1'b1 && n < 4000)
    begin
      @(posedge clk_i);
      n++;
      rises += (config_clock_o && !prev) ? 1 : 0;
      prev = config_clock_o;
      wr_n_i <= (n > 300 && n < 310) ? 1'b0 : 1'b1;
    end
    if (n >= 4000)
      give_up();
    check(rises, 8);
    rises = 0;
    repeat (600)
    begin
      @(posedge clk_i);
      rises += (config_clock_o && !prev) ? 1 : 0;
      prev = config_clock_o;
    end
    check(rises, 0);
  endtask
  task automatic run_par;
    int n;
    reset_dut(3'h6);
    wb_xfer(1'b1, cml_pkg::ADR_CTRL, 32'h0000_0002);
    @(posedge clk_i);
    check(upper_prom_address_oe_o, 1'b1);
    check({upper_prom_address_o, prom_addr_o},
          cml_pkg::DOWN_START_22);
    n = 0;
    while (prom_addr_o === 18'h3_ffff && n < 600)
    begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 600)
      give_up();
    check({upper_prom_address_o, prom_addr_o}, 22'h3f_fffe);
    check(config_clock_o, 1'b0);
  endtask
  initial
  begin
    void'($urandom(75946));
    reset_dut(3'h7);
    wb_xfer(1'b0, cml_pkg::ADR_FRAME, 32'h0000_0000);
    check(rd, 32'h0001_007e);
    wb_xfer(1'b1, cml_pkg::ADR_CTRL, 32'h0000_0007);
    wb_xfer(1'b0, cml_pkg::ADR_CTRL, 32'h0000_0000);
    check(rd, 32'h0000_0007);
    wb_xfer(1'b0, 8'h40, 32'h0000_0000);
    check(rd, 32'h0000_0000);
    for (int c = 0; c < 8; c++)
    begin
      reset_dut(3'(c));
      check(config_clock_oe_o,
            c == 0 || c == 4 || c == 5 || c == 6);
      check(prom_addr_oe_o, c == 4 || c == 6);
      check(upper_prom_address_oe_o, 1'b0);
      check(rdy_busy_o, c == 3 || c == 5);
      if (c == 4 || c == 6)
        check(prom_addr_o, c == 4 ? 22'h0 : cml_pkg::DOWN_START_18);
      wb_xfer(1'b0, cml_pkg::ADR_STATUS, 32'h0000_0000);
      check(rd[3:0], 4'h8 | 4'(c));
    end
    run_serial(cml_pkg::CHECK_CODE);
    run_serial(4'h0);
    run_async();
    run_par();
    tally_and_finish();
  end
endmodule
